// file: hdl/gps_pkg.sv
// Package of constants and types for the GPIO port with strobed byte bus
package gps_pkg;
	localparam int GPS_NPINS = 5;
	localparam int GPS_BUSW = 8;
	localparam int GPS_USER_PINS = 13;
	// AXI4-Lite register byte offsets
	localparam logic [5:0] GPS_OFF_DIR = 6'h00;
	localparam logic [5:0] GPS_OFF_OUT = 6'h04;
	localparam logic [5:0] GPS_OFF_IN = 6'h08;
	localparam logic [5:0] GPS_OFF_BUSCMD = 6'h0C;
	localparam logic [5:0] GPS_OFF_BUSDAT = 6'h10;
	localparam logic [5:0] GPS_OFF_STAT = 6'h14;
	localparam logic [5:0] GPS_OFF_IEN = 6'h18;
	localparam logic [5:0] GPS_OFF_ICLR = 6'h1C;
	localparam logic [5:0] GPS_OFF_STRB = 6'h20;
	// Bus command bits
	localparam int GPS_CMD_RD = 0;
	localparam int GPS_CMD_WR = 1;
	// Status bits
	localparam int GPS_ST_RDDONE = 0;
	localparam int GPS_ST_WRDONE = 1;
	localparam int GPS_ST_FRAME = 2;
	localparam int GPS_ST_BATLOW = 3;
	localparam int GPS_ST_BUSY = 4;
	localparam int GPS_NEVT = 4;
	// Pin indexes
	localparam int GPS_PIN_FRAME = 0;
	localparam int GPS_PIN_BAT = 1;
	localparam int GPS_PIN_SUPPLY = 2;
	localparam int GPS_PIN_RD = 3;
	localparam int GPS_PIN_WR = 4;
	// Strobe timing
	localparam int GPS_CLK_NS = 50;
	localparam int GPS_STRB_MIN_NS = 50;
	localparam int GPS_STRB_MIN_CYC = (GPS_STRB_MIN_NS + GPS_CLK_NS - 1) / GPS_CLK_NS;
	localparam logic [7:0] GPS_STRB_RST = 8'(GPS_STRB_MIN_CYC);
	localparam logic [1:0] GPS_RESP_OKAY = 2'h0;
	localparam logic [1:0] GPS_RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		GPS_IDLE,
		GPS_SETUP,
		GPS_LOW,
		GPS_HOLD
	} gps_bus_e;
endpackage : gps_pkg

// file: hdl/gps_edge_det.sv
// Rising edge detector for a vector of inputs
`timescale 1ns/1ps
module gps_edge_det #(
	parameter int W = 2
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [W-1:0] lvl,
	output logic [W-1:0] rise
);
	logic [W-1:0] prev_r;
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					prev_r[i] <= lvl[i];
				end else begin
					prev_r[i] <= lvl[i];
				end
			end
			assign rise[i] = lvl[i] & ~prev_r[i];
		end
	endgenerate
endmodule : gps_edge_det

// file: hdl/gps_port.sv
// GPIO port with five single pins and a strobed byte bus, AXI4-Lite slave
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - Thirteen user pins: five single, eight bus
// - All pins inputs after reset
// - Each single pin has own direction
// - Bus lines handled as one byte
// - Bus transfer strobe low at least 50 ns
// - Read strobe latches byte from bus
// - Write strobe drives and latches outgoing byte
// - Pin a read as frame mark input
// - Pin b read as battery low input
// - Pin c output high enables peripheral supply
// - Pin c input lets external circuit drive
module gps_port
	import gps_pkg::*;
#(
	parameter logic [7:0] STRB_CYC = gps_pkg::GPS_STRB_RST
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic master_reset_n,
	input wire logic [4:0] single_pin_in,
	output logic [4:0] single_pin_out,
	output logic [4:0] single_pin_oe,
	input wire logic [7:0] parallel_byte_lines_in,
	output logic [7:0] parallel_byte_lines_out,
	output logic [7:0] parallel_byte_lines_oe,
	output logic irq,
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import gps_pkg::*;

	function automatic logic known_addr(input logic [5:0] a);
		known_addr = (a == GPS_OFF_DIR) || (a == GPS_OFF_OUT) || (a == GPS_OFF_IN) ||
			(a == GPS_OFF_BUSCMD) || (a == GPS_OFF_BUSDAT) || (a == GPS_OFF_STAT) ||
			(a == GPS_OFF_IEN) || (a == GPS_OFF_ICLR) || (a == GPS_OFF_STRB);
	endfunction : known_addr

	wire srst = rst | ~master_reset_n;
	logic [4:0] dir_r;
	logic [4:0] out_r;
	logic [7:0] bus_out_r;
	logic [7:0] bus_in_r;
	logic [7:0] strb_len_r;
	logic [7:0] cnt_r;
	logic [7:0] pulse_len_r;
	logic is_wr_r;
	gps_bus_e st_r;
	logic [GPS_NEVT-1:0] stat_r;
	logic [GPS_NEVT-1:0] ien_r;
	logic rd_done_p;
	logic wr_done_p;
	// Write channel holding
	logic aw_hold_r;
	logic w_hold_r;
	logic [5:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;

	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire wr_fire = aw_hold_r & w_hold_r & ~s_axi_bvalid;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire wr_lo = wstrb_r[0];
	wire wr_dir = wr_fire & wr_lo & (awaddr_r == GPS_OFF_DIR);
	wire wr_out = wr_fire & wr_lo & (awaddr_r == GPS_OFF_OUT);
	wire wr_cmd = wr_fire & wr_lo & (awaddr_r == GPS_OFF_BUSCMD);
	wire wr_dat = wr_fire & wr_lo & (awaddr_r == GPS_OFF_BUSDAT);
	wire wr_ien = wr_fire & wr_lo & (awaddr_r == GPS_OFF_IEN);
	wire wr_iclr = wr_fire & wr_lo & (awaddr_r == GPS_OFF_ICLR);
	wire wr_strb = wr_fire & wr_lo & (awaddr_r == GPS_OFF_STRB);
	wire bus_busy = (st_r != GPS_IDLE);
	// Bus commands start only when idle, whatever the direction of the strobe pins
	wire start_rd = wr_cmd & ~bus_busy & wdata_r[GPS_CMD_RD];
	wire start_wr = wr_cmd & ~bus_busy & ~wdata_r[GPS_CMD_RD] & wdata_r[GPS_CMD_WR];
	wire [7:0] strb_eff = (strb_len_r < GPS_STRB_RST) ? GPS_STRB_RST : strb_len_r;

	// Event inputs: frame mark and battery low, read as inputs
	logic [1:0] pin_rise;
	gps_edge_det #(.W(2)) u_edge (
		.clk_sys(clk_sys),
		.rst(srst),
		.lvl({single_pin_in[GPS_PIN_BAT], single_pin_in[GPS_PIN_FRAME]}),
		.rise(pin_rise)
	);
	wire [GPS_NEVT-1:0] evt = {pin_rise[1] & ~dir_r[GPS_PIN_BAT],
		pin_rise[0] & ~dir_r[GPS_PIN_FRAME], wr_done_p, rd_done_p};

	// Pin direction and level, strobe length and interrupt enable registers
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			dir_r <= 5'h00;
			out_r <= 5'h1F;
			strb_len_r <= STRB_CYC;
			ien_r <= '0;
		end else begin
			if (wr_dir) begin
				dir_r <= wdata_r[4:0];
			end
			if (wr_out) begin
				out_r <= wdata_r[4:0];
			end
			if (wr_strb) begin
				strb_len_r <= wdata_r[7:0];
			end
			if (wr_ien) begin
				ien_r <= wdata_r[GPS_NEVT-1:0];
			end
		end
	end

	// Strobed byte bus sequencer
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_r <= GPS_IDLE;
			cnt_r <= 8'h00;
			pulse_len_r <= 8'h00;
			is_wr_r <= 1'b0;
			bus_out_r <= 8'h00;
			bus_in_r <= 8'h00;
		end else begin
			if (wr_dat & ~bus_busy) begin
				bus_out_r <= wdata_r[7:0];
			end
			case (st_r)
				GPS_IDLE: begin
					if (start_rd | start_wr) begin
						is_wr_r <= start_wr;
						st_r <= GPS_SETUP;
					end
				end
				GPS_SETUP: begin
					// Pulse length kept for the width checks
					cnt_r <= strb_eff;
					pulse_len_r <= strb_eff;
					st_r <= GPS_LOW;
				end
				GPS_LOW: begin
					if (cnt_r <= 8'h01) begin
						st_r <= GPS_HOLD;
						if (!is_wr_r) begin
							bus_in_r <= parallel_byte_lines_in;
						end
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				GPS_HOLD: begin
					st_r <= GPS_IDLE;
				end
				default: begin
					st_r <= GPS_IDLE;
				end
			endcase
		end
	end
	assign rd_done_p = (st_r == GPS_HOLD) & ~is_wr_r;
	assign wr_done_p = (st_r == GPS_HOLD) & is_wr_r;

	// Pin drivers, registered
	wire strb_low = (st_r == GPS_LOW);
	// Strobes high during a transfer, except the strobe of the transfer's direction in the low phase
	wire rd_strb_lvl = bus_busy ? ~(strb_low & ~is_wr_r) : out_r[GPS_PIN_RD];
	wire wr_strb_lvl = bus_busy ? ~(strb_low & is_wr_r) : out_r[GPS_PIN_WR];
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			single_pin_oe <= 5'h00;
			single_pin_out <= 5'h1F;
			parallel_byte_lines_oe <= 8'h00;
			parallel_byte_lines_out <= 8'h00;
		end else begin
			single_pin_oe <= dir_r | ({5{bus_busy}} & 5'h18);
			single_pin_out <= {wr_strb_lvl, rd_strb_lvl, out_r[2:0]};
			parallel_byte_lines_oe <= {8{bus_busy & is_wr_r}};
			parallel_byte_lines_out <= bus_out_r;
		end
	end

	// Interrupt status, set wins over clear
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			stat_r <= '0;
			irq <= 1'b0;
		end else begin
			stat_r <= (stat_r & ~(wr_iclr ? wdata_r[GPS_NEVT-1:0] : '0)) | evt;
			irq <= |(stat_r & ien_r);
		end
	end

	// AXI4-Lite write channel
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 6'h00;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= GPS_RESP_OKAY;
		end else begin
			s_axi_awready <= ~aw_hold_r & ~aw_take & ~s_axi_bvalid;
			s_axi_wready <= ~w_hold_r & ~w_take & ~s_axi_bvalid;
			if (aw_take) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (w_take) begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= known_addr(awaddr_r) ? GPS_RESP_OKAY : GPS_RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel
	logic [31:0] rd_mux;
	assign rd_mux =
		(s_axi_araddr == GPS_OFF_DIR) ? {27'h0, dir_r} :
		(s_axi_araddr == GPS_OFF_OUT) ? {27'h0, out_r} :
		(s_axi_araddr == GPS_OFF_IN) ? {27'h0, single_pin_in} :
		(s_axi_araddr == GPS_OFF_BUSDAT) ? {24'h0, bus_in_r} :
		(s_axi_araddr == GPS_OFF_STAT) ? {27'h0, bus_busy, stat_r} :
		(s_axi_araddr == GPS_OFF_IEN) ? {28'h0, ien_r} :
		(s_axi_araddr == GPS_OFF_STRB) ? {24'h0, strb_len_r} : 32'h0;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= GPS_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~ar_take;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= known_addr(s_axi_araddr) ? GPS_RESP_OKAY : GPS_RESP_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Checks
	// Strobe low run lengths for the width checks
	logic [7:0] rd_run_r;
	logic [7:0] wr_run_r;
	wire rd_pin_low = single_pin_oe[GPS_PIN_RD] & ~single_pin_out[GPS_PIN_RD];
	wire wr_pin_low = single_pin_oe[GPS_PIN_WR] & ~single_pin_out[GPS_PIN_WR];
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rd_run_r <= 8'h00;
			wr_run_r <= 8'h00;
		end else begin
			rd_run_r <= rd_pin_low ? rd_run_r + {7'h00, rd_run_r != 8'hFF} : 8'h00;
			wr_run_r <= wr_pin_low ? wr_run_r + {7'h00, wr_run_r != 8'hFF} : 8'h00;
		end
	end
	property p_pins_input_after_reset;
		@(posedge clk_sys) $past(srst) |-> (single_pin_oe == 5'h00) && (parallel_byte_lines_oe == 8'h00);
	endproperty
	a_pins_input_after_reset: assert property (p_pins_input_after_reset) else $error("pins not inputs after reset");
	property p_strobe_width;
		@(posedge clk_sys) disable iff (srst)
			$rose(single_pin_out[GPS_PIN_RD]) && $past(st_r == GPS_HOLD) |->
			(rd_run_r == pulse_len_r) && (rd_run_r >= 8'(GPS_STRB_MIN_CYC));
	endproperty
	a_strobe_width: assert property (p_strobe_width) else $error("read strobe too short");
	property p_wr_strobe_width;
		@(posedge clk_sys) disable iff (srst)
			$rose(single_pin_out[GPS_PIN_WR]) && $past(st_r == GPS_HOLD) |->
			(wr_run_r == pulse_len_r) && (wr_run_r >= 8'(GPS_STRB_MIN_CYC));
	endproperty
	a_wr_strobe_width: assert property (p_wr_strobe_width) else $error("write strobe too short");
	property p_rd_latch;
		@(posedge clk_sys) disable iff (srst)
			rd_done_p |-> bus_in_r == $past(parallel_byte_lines_in);
	endproperty
	a_rd_latch: assert property (p_rd_latch) else $error("read byte not latched");
	property p_wr_drive;
		@(posedge clk_sys) disable iff (srst)
			(single_pin_oe[GPS_PIN_WR] && !single_pin_out[GPS_PIN_WR] && $past(bus_busy)) |->
			parallel_byte_lines_oe == 8'hFF && $stable(parallel_byte_lines_out);
	endproperty
	a_wr_drive: assert property (p_wr_drive) else $error("byte not held during write strobe");
	property p_supply_follow;
		@(posedge clk_sys) disable iff (srst)
			wr_out |=> ##1 single_pin_out[GPS_PIN_SUPPLY] == $past(wdata_r[GPS_PIN_SUPPLY], 2);
	endproperty
	a_supply_follow: assert property (p_supply_follow) else $error("supply pin not updated");
	property p_dir_follow;
		@(posedge clk_sys) disable iff (srst)
			wr_dir && !bus_busy |=> ##1 single_pin_oe[2:0] == $past(wdata_r[2:0], 2);
	endproperty
	a_dir_follow: assert property (p_dir_follow) else $error("direction not applied");
	property p_strobe_idle_high;
		@(posedge clk_sys) disable iff (srst)
			(st_r == GPS_IDLE) && $past(st_r == GPS_IDLE) && $past(out_r[4:3] == 2'h3)
			|-> single_pin_out[4:3] == 2'h3;
	endproperty
	a_strobe_idle_high: assert property (p_strobe_idle_high) else $error("strobe low while idle");
	property p_frame_event;
		@(posedge clk_sys) disable iff (srst)
			evt[GPS_ST_FRAME] |=> stat_r[GPS_ST_FRAME];
	endproperty
	a_frame_event: assert property (p_frame_event) else $error("frame mark lost");
	property p_strobe_high_busy;
		@(posedge clk_sys) disable iff (srst)
			$past(bus_busy) && !$past(strb_low) |->
			(single_pin_out[4:3] == 2'h3) && (single_pin_oe[4:3] == 2'h3);
	endproperty
	a_strobe_high_busy: assert property (p_strobe_high_busy) else $error("strobe low outside pulse");
	property p_rd_lines_released;
		@(posedge clk_sys) disable iff (srst)
			$past(bus_busy) && !$past(is_wr_r) |-> parallel_byte_lines_oe == 8'h00;
	endproperty
	a_rd_lines_released: assert property (p_rd_lines_released) else $error("lines driven during read");
	property p_irq_level;
		@(posedge clk_sys) disable iff (srst)
			irq == |$past(stat_r & ien_r);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");
endmodule : gps_port

// file: verif/gps_far_side.sv
// Far-side peripheral model for the GPIO port
`timescale 1ns/1ps
module gps_far_side (
	input wire logic clk_sys,
	input wire logic rst_req,
	input wire logic [4:0] pin_drv,
	input wire logic [7:0] byte_drv,
	input wire logic [4:0] pin_out,
	input wire logic [4:0] pin_oe,
	input wire logic [7:0] line_out,
	input wire logic [7:0] line_oe,
	output logic [4:0] pin_lvl,
	output logic [7:0] line_lvl,
	output logic master_reset_n,
	output logic [7:0] wr_byte,
	output logic [7:0] low_cyc,
	output logic unstable
);
	logic [7:0] hold_r;
	logic prev_r;
	logic wr_low;
	initial begin
		hold_r = 8'h00;
		prev_r = 1'b0;
		wr_byte = 8'h00;
		low_cyc = 8'h00;
		unstable = 1'b0;
	end
	// Undriven pins left to the far side
	assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & pin_drv);
	assign line_lvl = (line_oe & line_out) | (~line_oe & byte_drv);
	// Open-collector reset, low 48 cycles
	assign master_reset_n = (hold_r == 8'h00);
	assign wr_low = pin_oe[4] & ~pin_out[4];
	always @(posedge clk_sys) begin
		if (rst_req) begin
			hold_r <= 8'h30;
		end else if (hold_r != 8'h00) begin
			hold_r <= hold_r - 8'h01;
		end
		if (wr_low && !prev_r) begin
			low_cyc <= 8'h01;
			wr_byte <= line_lvl;
		end else if (wr_low) begin
			low_cyc <= low_cyc + 8'h01;
			if (line_lvl !== wr_byte || line_oe !== 8'hFF) begin
				unstable <= 1'b1;
			end
		end
		prev_r <= wr_low;
	end
endmodule : gps_far_side

// file: verif/test_gps_port.sv
// Testbench for the GPIO port with strobed byte bus
`timescale 1ns/1ps
module test_gps_port;
	import gps_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic rst_req = 1'b0;
	logic [4:0] pin_drv = 5'h18;
	logic [7:0] byte_drv = 8'hA5;
	logic [5:0] s_axi_awaddr = 6'h00;
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b1;
	logic [5:0] s_axi_araddr = 6'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, rdat;
	logic master_reset_n, irq, unstable;
	logic [4:0] pin_in, pin_out, pin_oe;
	logic [7:0] line_in, line_out, line_oe, wr_byte, low_cyc;
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	always #25 clk_sys = ~clk_sys;
	gps_port dut_u (.clk_sys(clk_sys), .rst(rst), .master_reset_n(master_reset_n),
		.single_pin_in(pin_in), .single_pin_out(pin_out), .single_pin_oe(pin_oe),
		.parallel_byte_lines_in(line_in), .parallel_byte_lines_out(line_out),
		.parallel_byte_lines_oe(line_oe), .irq(irq), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	gps_far_side far_u (.clk_sys(clk_sys), .rst_req(rst_req), .pin_drv(pin_drv),
		.byte_drv(byte_drv), .pin_out(pin_out), .pin_oe(pin_oe), .line_out(line_out),
		.line_oe(line_oe), .pin_lvl(pin_in), .line_lvl(line_in),
		.master_reset_n(master_reset_n), .wr_byte(wr_byte), .low_cyc(low_cyc),
		.unstable(unstable));
	task automatic print_verdict;
		if (fails == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
		repeat (2) @(posedge clk_sys);
	endtask : wr
	task automatic rd(input logic [5:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
	endtask : rd
	task automatic wait_idle;
		for (int k = 0; k < 50; k++) begin
			rd(GPS_OFF_STAT);
			if (!rdat[GPS_ST_BUSY]) break;
		end
	endtask : wait_idle
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			print_verdict;
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk($bits(pin_oe) + $bits(line_oe), GPS_USER_PINS);
		chk({pin_oe, line_oe}, 13'h0);
		rd(GPS_OFF_DIR);
		chk(rdat, 32'h0);
		rd(GPS_OFF_OUT);
		chk(rdat, 32'h1F);
		rd(GPS_OFF_STRB);
		chk(rdat, {24'h0, GPS_STRB_RST});
		wr(GPS_OFF_DIR, 32'h07);
		wr(GPS_OFF_OUT, 32'h04);
		chk(pin_oe, 5'h07);
		chk(pin_in[GPS_PIN_SUPPLY], 1'b1);
		wr(GPS_OFF_OUT, 32'h00);
		chk(pin_in[GPS_PIN_SUPPLY], 1'b0);
		wr(GPS_OFF_DIR, 32'h03);
		pin_drv <= 5'h1C;
		repeat (3) @(posedge clk_sys);
		rd(GPS_OFF_IN);
		chk(rdat[4:0], 5'h1C);
		wr(GPS_OFF_DIR, 32'h00);
		wr(GPS_OFF_IEN, 32'h0F);
		pin_drv <= 5'h1F;
		repeat (3) @(posedge clk_sys);
		rd(GPS_OFF_STAT);
		chk(rdat[3:0], 4'hC);
		chk(irq, 1'b1);
		wr(GPS_OFF_ICLR, 32'h0F);
		chk(irq, 1'b0);
		wr(GPS_OFF_BUSCMD, 32'h01);
		wait_idle;
		chk(rdat[GPS_ST_RDDONE], 1'b1);
		rd(GPS_OFF_BUSDAT);
		chk(rdat[7:0], 8'hA5);
		wr(GPS_OFF_STRB, 32'h02);
		wr(GPS_OFF_BUSDAT, 32'h3C);
		wr(GPS_OFF_BUSCMD, 32'h02);
		wait_idle;
		chk(rdat[GPS_ST_WRDONE], 1'b1);
		chk(wr_byte, 8'h3C);
		chk(low_cyc, 8'h02);
		chk(unstable, 1'b0);
		chk(line_oe, 8'h00);
		chk({pin_oe[4:3], pin_in[4:3]}, 4'h3);
		wr(6'h24, 32'h0);
		chk(resp, GPS_RESP_SLVERR);
		wr(GPS_OFF_DIR, 32'h1F);
		rst_req <= 1'b1;
		@(posedge clk_sys);
		rst_req <= 1'b0;
		repeat (10) @(posedge clk_sys);
		chk(pin_oe, 5'h00);
		repeat (50) @(posedge clk_sys);
		rd(GPS_OFF_OUT);
		chk(rdat, 32'h1F);
		rd(GPS_OFF_STAT);
		chk(rdat, 32'h0);
		print_verdict;
	end
endmodule : test_gps_port
